// >>> core/ptc_pkg.sv
// Constants for the pixel test and constant register bank
`default_nettype none
package ptc_pkg;
   localparam logic [7:0] A_PIXEL_MODE = 8'h00;
   localparam logic [7:0] A_COLOUR_PATH = 8'h04;
   localparam logic [7:0] A_FOG_CTRL = 8'h08;
   localparam logic [7:0] A_DIRECT_MODE = 8'h0C;
   localparam logic [7:0] A_INTR_CTRL = 8'h10;
   localparam logic [7:0] A_STIPPLE = 8'h14;
   localparam logic [7:0] A_COLOR_LOCAL = 8'h18;
   localparam logic [7:0] A_COLOR_OTHER = 8'h1C;
   localparam logic [7:0] A_FOG_RGB = 8'h20;
   localparam logic [7:0] A_DEPTH_ALPHA = 8'h24;
   localparam logic [7:0] A_KEY_LOWER = 8'h28;
   localparam logic [7:0] A_KEY_UPPER = 8'h2C;
   localparam logic [7:0] A_HOST_INTR = 8'h30;
   localparam logic [7:0] A_RT_BASE = 8'h34;
   localparam logic [7:0] A_RT_PITCH = 8'h38;
   localparam logic [7:0] A_AUX_BASE = 8'h3C;
   // Writable bit masks; reserved bits read as zero
   localparam logic [31:0] M_RGB = 32'h00FFFFFF;
   localparam logic [31:0] M_DEPTH_ALPHA = 32'hFF00FFFF;
   localparam logic [31:0] M_KEY_UPPER = 32'h1FFFFFFF;
   localparam logic [31:0] M_BASE = 32'h00FFFFF0;
   localparam logic [31:0] M_PITCH_LIN = 32'h0000BFFF;
   localparam logic [31:0] M_PITCH_TILE = 32'h0000807F;
   localparam logic [31:0] RST_VAL = 32'h00000000;
   // Pixel mode fields
   localparam int PM_KEY_EN = 1;
   localparam int PM_DEPTH_EN = 4;
   localparam int PM_FUNC_LO = 5;
   localparam int PM_RGB_WR = 9;
   localparam int PM_DEPTH_WR = 10;
   localparam int PM_BIAS_EN = 16;
   localparam int PM_CONST_SRC = 20;
   // Key range fields
   localparam int KR_MODE_LO = 24;
   localparam int KR_UNION = 27;
   localparam int KR_RANGE_EN = 28;
   // Interrupt control fields
   localparam int IC_USER_EN = 5;
   localparam int IC_USER_PEND = 11;
   localparam int IC_TAG_LO = 12;
   // Host interrupt command fields
   localparam int HI_NO_RAISE = 0;
   localparam int HI_WAIT = 1;
   localparam int HI_TAG_LO = 2;
   // Other fields
   localparam int PITCH_TILED = 15;
   localparam int DW_PIPE_EN = 8;
   localparam logic [3:0] DW_FMT_DEPTH = 4'hF;
   localparam int FOG_EN = 0;
   typedef enum logic [2:0] {
      DC_NEVER = 3'h0, DC_LT = 3'h1, DC_EQ = 3'h2, DC_LE = 3'h3,
      DC_GT = 3'h4, DC_NE = 3'h5, DC_GE = 3'h6, DC_ALWAYS = 3'h7
   } ptc_depth_code_t;
endpackage : ptc_pkg
`default_nettype wire

// >>> core/ptc_regs.sv
// Pixel test and constant register bank with AHB-Lite slave
`default_nettype none
module ptc_regs #(
   parameter logic [1:0] CP_SEL_OTHER = 2'h1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic px_valid,
   input wire logic [15:0] px_depth_src,
   input wire logic [15:0] px_depth_dst,
   input wire logic [23:0] px_tex_rgb,
   output logic px_out_valid,
   output logic px_depth_pass,
   output logic px_rgb_write,
   output logic px_depth_write,
   output logic px_key_reject,
   output logic [15:0] px_depth_out,
   output logic [23:0] cc_local_rgb,
   output logic [7:0] ac_local_alpha,
   output logic cc_other_sel,
   output logic [23:0] cc_other_rgb,
   output logic ac_other_sel,
   output logic [7:0] ac_other_alpha,
   output logic [23:0] clear_fill_rgb,
   output logic [15:0] clear_fill_depth,
   output logic [7:0] const_alpha,
   input wire logic [3:0] dw_format,
   output logic dw_use_const_rgb,
   output logic [23:0] dw_const_rgb,
   output logic fog_enable,
   output logic [23:0] fog_rgb,
   output logic [31:0] stipple_value,
   output logic [23:0] rt_base,
   output logic [15:0] rt_pitch,
   output logic [23:0] aux_base,
   output logic user_irq_pending,
   output logic cmd_stall
);
   import ptc_pkg::*;

   logic [31:0] pixel_mode_r, colour_path_r, fog_ctrl_r, direct_mode_r;
   logic [31:0] intr_ctrl_r, stipple_r, color_local_r, color_other_r;
   logic [31:0] fog_rgb_r, depth_alpha_r, key_lower_r, key_upper_r;
   logic [31:0] rt_base_r, rt_pitch_r, aux_base_r;
   logic [7:0] wr_addr_r;
   logic wr_pend_r;
   logic stall_r;

   // Bus slave: zero wait states, always OKAY
   wire addr_ok = hsel && hready && htrans[1];
   wire wr_now = wr_pend_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= addr_ok && hwrite;
         wr_addr_r <= haddr[7:0];
      end
   end

   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h00000000;
      if (a == A_PIXEL_MODE) begin
         v = pixel_mode_r;
      end else if (a == A_COLOUR_PATH) begin
         v = colour_path_r;
      end else if (a == A_FOG_CTRL) begin
         v = fog_ctrl_r;
      end else if (a == A_DIRECT_MODE) begin
         v = direct_mode_r;
      end else if (a == A_INTR_CTRL) begin
         v = intr_ctrl_r;
      end else if (a == A_STIPPLE) begin
         v = stipple_r;
      end else if (a == A_COLOR_LOCAL) begin
         v = color_local_r;
      end else if (a == A_COLOR_OTHER) begin
         v = color_other_r;
      end else if (a == A_FOG_RGB) begin
         v = fog_rgb_r;
      end else if (a == A_DEPTH_ALPHA) begin
         v = depth_alpha_r;
      end else if (a == A_KEY_LOWER) begin
         v = key_lower_r;
      end else if (a == A_KEY_UPPER) begin
         v = key_upper_r;
      end else if (a == A_RT_BASE) begin
         v = rt_base_r;
      end else if (a == A_RT_PITCH) begin
         v = rt_pitch_r;
      end else if (a == A_AUX_BASE) begin
         v = aux_base_r;
      end
      return v;
   endfunction : rd_mux

   // Read data registered at the address phase; write-only and unmapped read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= RST_VAL;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_mux(haddr[7:0]);
      end
   end

   // Plain configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pixel_mode_r <= RST_VAL;
         colour_path_r <= RST_VAL;
         fog_ctrl_r <= RST_VAL;
         direct_mode_r <= RST_VAL;
         stipple_r <= RST_VAL;
         color_local_r <= RST_VAL;
         color_other_r <= RST_VAL;
         fog_rgb_r <= RST_VAL;
         depth_alpha_r <= RST_VAL;
         key_lower_r <= RST_VAL;
         key_upper_r <= RST_VAL;
         rt_base_r <= RST_VAL;
         rt_pitch_r <= RST_VAL;
         aux_base_r <= RST_VAL;
      end else if (wr_now) begin
         if (wr_addr_r == A_PIXEL_MODE) begin
            pixel_mode_r <= hwdata;
         end else if (wr_addr_r == A_COLOUR_PATH) begin
            colour_path_r <= hwdata;
         end else if (wr_addr_r == A_FOG_CTRL) begin
            fog_ctrl_r <= hwdata;
         end else if (wr_addr_r == A_DIRECT_MODE) begin
            direct_mode_r <= hwdata;
         end else if (wr_addr_r == A_STIPPLE) begin
            stipple_r <= hwdata;
         end else if (wr_addr_r == A_COLOR_LOCAL) begin
            color_local_r <= hwdata;
         end else if (wr_addr_r == A_COLOR_OTHER) begin
            color_other_r <= hwdata;
         end else if (wr_addr_r == A_FOG_RGB) begin
            fog_rgb_r <= hwdata & M_RGB;
         end else if (wr_addr_r == A_DEPTH_ALPHA) begin
            depth_alpha_r <= hwdata & M_DEPTH_ALPHA;
         end else if (wr_addr_r == A_KEY_LOWER) begin
            key_lower_r <= hwdata & M_RGB;
         end else if (wr_addr_r == A_KEY_UPPER) begin
            key_upper_r <= hwdata & M_KEY_UPPER;
         end else if (wr_addr_r == A_RT_BASE) begin
            rt_base_r <= hwdata & M_BASE;
         end else if (wr_addr_r == A_AUX_BASE) begin
            aux_base_r <= hwdata & M_BASE;
         end else if (wr_addr_r == A_RT_PITCH) begin
            rt_pitch_r <= hwdata & (hwdata[PITCH_TILED] ? M_PITCH_TILE : M_PITCH_LIN);
         end
      end
   end

   // Host interrupt command; dropped when user interrupts are disabled
   wire cmd_wr = wr_now && (wr_addr_r == A_HOST_INTR);
   wire cmd_live = cmd_wr && intr_ctrl_r[IC_USER_EN];
   wire raise = cmd_live && !hwdata[HI_NO_RAISE];
   wire ic_wr = wr_now && (wr_addr_r == A_INTR_CTRL);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         intr_ctrl_r <= RST_VAL;
      end else begin
         if (ic_wr) begin
            intr_ctrl_r <= hwdata;
         end
         if (cmd_live) begin
            intr_ctrl_r[IC_TAG_LO +: 8] <= hwdata[HI_TAG_LO +: 8];
         end
         // Set beats a simultaneous software clear
         if (raise) begin
            intr_ctrl_r[IC_USER_PEND] <= 1'b1;
         end
      end
   end

   // Stall holds until the pending bit drops; no stall if nothing pending
   wire pend_after = raise || intr_ctrl_r[IC_USER_PEND];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stall_r <= 1'b0;
      end else if (cmd_live && hwdata[HI_WAIT] && pend_after) begin
         stall_r <= 1'b1;
      end else if (!intr_ctrl_r[IC_USER_PEND]) begin
         stall_r <= 1'b0;
      end
   end
   assign cmd_stall = stall_r;
   assign user_irq_pending = intr_ctrl_r[IC_USER_PEND];

   // Pixel tests: key runs on post-texture colour, ahead of lighting and fog
   logic [15:0] biased, cmp_src;
   logic cmp_ok, depth_ok, key_hit;
   logic [2:0] in_rng, prohib;
   ptc_depth_code_t code;

   always_comb begin
      biased = pixel_mode_r[PM_BIAS_EN] ? 16'(px_depth_src + depth_alpha_r[15:0]) : px_depth_src;
      cmp_src = pixel_mode_r[PM_CONST_SRC] ? depth_alpha_r[15:0] : biased;
      code = ptc_depth_code_t'(pixel_mode_r[PM_FUNC_LO +: 3]);
      case (code)
         DC_NEVER: cmp_ok = 1'b0;
         DC_LT: cmp_ok = cmp_src < px_depth_dst;
         DC_EQ: cmp_ok = cmp_src == px_depth_dst;
         DC_LE: cmp_ok = cmp_src <= px_depth_dst;
         DC_GT: cmp_ok = cmp_src > px_depth_dst;
         DC_NE: cmp_ok = cmp_src != px_depth_dst;
         DC_GE: cmp_ok = cmp_src >= px_depth_dst;
         default: cmp_ok = 1'b1;
      endcase
      depth_ok = !pixel_mode_r[PM_DEPTH_EN] || cmp_ok;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_comp
         wire [7:0] c = px_tex_rgb[8*gi +: 8];
         // Inclusive on both limits; lower above upper is software's fault
         assign in_rng[gi] = (c >= key_lower_r[8*gi +: 8]) && (c <= key_upper_r[8*gi +: 8]);
         assign prohib[gi] = key_upper_r[KR_MODE_LO + gi] ? !in_rng[gi] : in_rng[gi];
      end
   endgenerate

   always_comb begin
      if (!pixel_mode_r[PM_KEY_EN]) begin
         key_hit = 1'b0;
      end else if (key_upper_r[KR_RANGE_EN]) begin
         key_hit = key_upper_r[KR_UNION] ? |prohib : &prohib;
      end else begin
         key_hit = px_tex_rgb == key_lower_r[23:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         px_out_valid <= 1'b0;
         px_depth_pass <= 1'b0;
         px_rgb_write <= 1'b0;
         px_depth_write <= 1'b0;
         px_key_reject <= 1'b0;
         px_depth_out <= 16'h0000;
      end else begin
         px_out_valid <= px_valid;
         px_depth_pass <= px_valid && depth_ok;
         px_key_reject <= px_valid && key_hit;
         px_rgb_write <= px_valid && depth_ok && !key_hit && pixel_mode_r[PM_RGB_WR];
         px_depth_write <= px_valid && depth_ok && !key_hit && pixel_mode_r[PM_DEPTH_WR];
         px_depth_out <= biased;
      end
   end

   // Constant taps straight from the register flops
   assign cc_local_rgb = color_local_r[23:0];
   assign ac_local_alpha = color_local_r[31:24];
   assign cc_other_sel = colour_path_r[1:0] == CP_SEL_OTHER;
   assign ac_other_sel = colour_path_r[3:2] == CP_SEL_OTHER;
   assign cc_other_rgb = color_other_r[23:0];
   assign ac_other_alpha = color_other_r[31:24];
   assign clear_fill_rgb = color_other_r[23:0];
   assign clear_fill_depth = depth_alpha_r[15:0];
   assign const_alpha = depth_alpha_r[31:24];
   assign dw_use_const_rgb = (dw_format == DW_FMT_DEPTH) && direct_mode_r[DW_PIPE_EN];
   assign dw_const_rgb = color_other_r[23:0];
   assign fog_enable = fog_ctrl_r[FOG_EN];
   assign fog_rgb = fog_rgb_r[23:0];
   assign stipple_value = stipple_r;
   assign rt_base = rt_base_r[23:0];
   assign rt_pitch = rt_pitch_r[15:0];
   assign aux_base = aux_base_r[23:0];

   chk_write_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      px_rgb_write |-> px_depth_pass && !px_key_reject)
      else $error("colour written without pass");
   chk_depth_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      px_depth_write |-> px_depth_pass && $past(pixel_mode_r[PM_DEPTH_WR]))
      else $error("depth written without enable");
   chk_never_code: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && pixel_mode_r[PM_DEPTH_EN] && code == DC_NEVER |=> !px_depth_pass)
      else $error("never code passed");
   chk_disabled_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && !pixel_mode_r[PM_DEPTH_EN] |=> px_depth_pass)
      else $error("disabled test failed pixel");
   chk_key_exact: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && pixel_mode_r[PM_KEY_EN] && !key_upper_r[KR_RANGE_EN]
      && px_tex_rgb == key_lower_r[23:0] |=> px_key_reject && !px_rgb_write)
      else $error("key match not rejected");
   chk_raise_pend: assert property (@(posedge hclk) disable iff (!hresetn)
      raise |=> user_irq_pending)
      else $error("user interrupt not raised");
   // A stall already draining may still fall during a dropped write
   chk_drop_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_wr && !intr_ctrl_r[IC_USER_EN] && !ic_wr |=> $stable(intr_ctrl_r) && !$rose(cmd_stall))
      else $error("dropped command had effect");
   chk_stall_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_stall && user_irq_pending |=> cmd_stall)
      else $error("stall released while pending");
   chk_stall_free: assert property (@(posedge hclk) disable iff (!hresetn)
      !user_irq_pending && !raise |=> !cmd_stall)
      else $error("stall without pending");
   chk_tag_copy: assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_live |=> intr_ctrl_r[19:12] == $past(hwdata[9:2]))
      else $error("tag not copied");
   chk_base_low: assert property (@(posedge hclk) disable iff (!hresetn)
      rt_base_r[3:0] == 4'h0 && aux_base_r[3:0] == 4'h0)
      else $error("base low bits set");
   chk_pitch_tile: assert property (@(posedge hclk) disable iff (!hresetn)
      rt_pitch_r[PITCH_TILED] |-> rt_pitch_r[14:7] == 8'h00)
      else $error("tiled pitch reserved bits set");
   chk_always_code: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && code == DC_ALWAYS |=> px_depth_pass)
      else $error("always code failed pixel");
   chk_rgb_off: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && !pixel_mode_r[PM_RGB_WR] |=> !px_rgb_write)
      else $error("colour written while disabled");
   chk_depth_off: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && !pixel_mode_r[PM_DEPTH_WR] |=> !px_depth_write)
      else $error("depth written while disabled");
   chk_reject_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
      px_key_reject |-> !px_rgb_write && !px_depth_write)
      else $error("rejected pixel written");
   chk_key_off: assert property (@(posedge hclk) disable iff (!hresetn)
      px_valid && !pixel_mode_r[PM_KEY_EN] |=> !px_key_reject)
      else $error("key reject while disabled");
   chk_pend_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      user_irq_pending && !ic_wr |=> user_irq_pending)
      else $error("pending dropped without clear");
   chk_local_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_now && wr_addr_r == A_COLOR_LOCAL |=> color_local_r == $past(hwdata))
      else $error("local colour write lost");
   chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      fog_rgb_r[31:24] == 8'h00 && depth_alpha_r[23:16] == 8'h00)
      else $error("reserved bits set");
endmodule : ptc_regs
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the pixel test and constant register bank
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ptc_pkg::*;
   localparam logic [1:0] CP_OTHER = 2'h1;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic px_valid = 1'b0;
   logic [15:0] px_depth_src = 16'h0;
   logic [15:0] px_depth_dst = 16'h0;
   logic [23:0] px_tex_rgb = 24'h0;
   logic [3:0] dw_format = 4'h0;
   logic [31:0] hrdata, stipple_value;
   logic hready, hresp, px_out_valid, px_depth_pass, px_rgb_write, px_depth_write, px_key_reject;
   logic cc_other_sel, ac_other_sel, dw_use_const_rgb, fog_enable, user_irq_pending, cmd_stall;
   logic [15:0] px_depth_out, clear_fill_depth, rt_pitch;
   logic [23:0] cc_local_rgb, cc_other_rgb, clear_fill_rgb, dw_const_rgb, fog_rgb, rt_base, aux_base;
   logic [7:0] ac_local_alpha, ac_other_alpha, const_alpha;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h23A0;
   // Shadow of every write made through wr, indexed by word offset
   logic [31:0] wv [16];

   ptc_regs #(.CP_SEL_OTHER(CP_OTHER)) uut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hready), .hrdata,
      .hreadyout(hready), .hresp, .px_valid, .px_depth_src, .px_depth_dst, .px_tex_rgb, .px_out_valid,
      .px_depth_pass, .px_rgb_write, .px_depth_write, .px_key_reject, .px_depth_out, .cc_local_rgb,
      .ac_local_alpha, .cc_other_sel, .cc_other_rgb, .ac_other_sel, .ac_other_alpha, .clear_fill_rgb,
      .clear_fill_depth, .const_alpha, .dw_format, .dw_use_const_rgb, .dw_const_rgb, .fog_enable,
      .fog_rgb, .stipple_value, .rt_base, .rt_pitch, .aux_base, .user_irq_pending, .cmd_stall
   );

   always #12.5 hclk = ~hclk;

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   function automatic logic dpass(input logic [2:0] op, input logic [15:0] s, input logic [15:0] d);
      case (op)
         DC_NEVER: return 1'b0;
         DC_LT: return s < d;
         DC_EQ: return s == d;
         DC_LE: return s <= d;
         DC_GT: return s > d;
         DC_NE: return s != d;
         DC_GE: return s >= d;
         default: return 1'b1;
      endcase
   endfunction : dpass

   // Prohibited flag per component is inside-range flipped by its mode bit
   function automatic logic kexp(input logic [31:0] lo, input logic [31:0] hi, input logic [23:0] p);
      logic [2:0] pr;
      for (int i = 0; i < 3; i++) begin
         pr[i] = hi[KR_MODE_LO + i] ^ (p[8*i +: 8] >= lo[8*i +: 8] && p[8*i +: 8] <= hi[8*i +: 8]);
      end
      if (!hi[KR_RANGE_EN]) return p == lo[23:0];
      return hi[KR_UNION] ? |pr : &pr;
   endfunction : kexp

   function automatic logic [31:0] msk(input logic [7:0] a, input logic [31:0] v);
      case (a)
         A_FOG_RGB, A_KEY_LOWER: return v & M_RGB;
         A_DEPTH_ALPHA: return v & M_DEPTH_ALPHA;
         A_KEY_UPPER: return v & M_KEY_UPPER;
         A_RT_BASE, A_AUX_BASE: return v & M_BASE;
         A_RT_PITCH: return v & (v[PITCH_TILED] ? M_PITCH_TILE : M_PITCH_LIN);
         A_HOST_INTR: return 32'h0;
         default: return v;
      endcase
   endfunction : msk

   task automatic tally_and_finish();
      $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1) begin
         bad_count++;
         $display("[FAIL] hready expected 1 seen %b", hready);
         tally_and_finish();
      end
   endtask : wait_rdy

   // Address phase held until hready, then data phase until hready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
      wv[a[5:2]] = d;
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] x;
      bus(a, 1'b0, 32'h0, x);
      `CHK("readback", {1'b0, ex}, {hresp, x})
   endtask : rdchk

   task automatic settle();
      @(posedge hclk);
      #1;
   endtask : settle

   task automatic pix(input logic [15:0] s, input logic [15:0] d, input logic [23:0] c);
      @(posedge hclk);
      px_valid <= 1'b1;
      px_depth_src <= s;
      px_depth_dst <= d;
      px_tex_rgb <= c;
      @(posedge hclk);
      px_valid <= 1'b0;
      #1;
   endtask : pix

   initial begin
      logic [31:0] pm, lo, hi, x;
      logic [15:0] s, d;
      logic [23:0] c;
      logic pass, rej;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      `CHK("reset outs", 3'h0, {user_irq_pending, cmd_stall, fog_enable})
      for (int i = 0; i < 17; i++) rdchk(8'(i * 4), 32'h0);
      $display("reset test done");
      // Two passes so the pitch mask is seen in both layouts
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 16; i++) begin
            if (i != 4) wr(8'(i * 4), rnd());
         end
         x = rnd();
         x[PITCH_TILED] = k[0];
         wr(A_RT_PITCH, x);
         dw_format <= k[0] ? DW_FMT_DEPTH : 4'(rnd());
         for (int i = 0; i < 16; i++) begin
            if (i != 4) rdchk(8'(i * 4), msk(8'(i * 4), wv[i]));
         end
         #1;
         `CHK("local", {cc_local_rgb, ac_local_alpha}, {wv[6][23:0], wv[6][31:24]})
         `CHK("other", {cc_other_sel, ac_other_sel, cc_other_rgb, ac_other_alpha}, {wv[1][1:0] == CP_OTHER,
            wv[1][3:2] == CP_OTHER, wv[7][23:0], wv[7][31:24]})
         `CHK("clear", {clear_fill_rgb, clear_fill_depth, const_alpha},
            {wv[7][23:0], wv[9][15:0], wv[9][31:24]})
         `CHK("direct", {dw_use_const_rgb, dw_const_rgb},
            {dw_format == DW_FMT_DEPTH && wv[3][DW_PIPE_EN], wv[7][23:0]})
         `CHK("fog", {fog_enable, fog_rgb, stipple_value}, {wv[2][FOG_EN], wv[8][23:0], wv[5]})
         `CHK("bufs", {rt_base, rt_pitch, aux_base}, {24'(msk(A_RT_BASE, wv[13])), 16'(msk(A_RT_PITCH, wv[14])),
            24'(msk(A_AUX_BASE, wv[15]))})
      end
      bus(8'h40, 1'b1, rnd(), x);
      rdchk(8'h40, 32'h0);
      rdchk(A_PIXEL_MODE, wv[0]);
      $display("register test done");
      // Zero bias so the plain source depth is compared
      wr(A_DEPTH_ALPHA, 32'h0);
      for (int i = 0; i < 48; i++) begin
         pm = (rnd() & 32'h00000612) | (32'(i % 8) << PM_FUNC_LO);
         lo = rnd() & M_RGB;
         hi = (lo | rnd()) & M_KEY_UPPER;
         case (i % 3)
            0: c = lo[23:0];
            1: c = lo[23:0] | (24'(rnd()) & hi[23:0]);
            default: c = 24'(rnd());
         endcase
         d = 16'(rnd());
         s = i[0] ? d : 16'(rnd());
         wr(A_PIXEL_MODE, pm);
         wr(A_KEY_LOWER, lo);
         wr(A_KEY_UPPER, hi);
         pix(s, d, c);
         pass = !pm[PM_DEPTH_EN] || dpass(pm[PM_FUNC_LO +: 3], s, d);
         rej = pm[PM_KEY_EN] && kexp(lo, hi, c);
         `CHK("depth pass", {1'b1, pass}, {px_out_valid, px_depth_pass})
         `CHK("key reject", rej, px_key_reject)
         `CHK("writes", {pass && pm[PM_RGB_WR] && !rej, pass && pm[PM_DEPTH_WR] && !rej},
            {px_rgb_write, px_depth_write})
      end
      wr(A_PIXEL_MODE, 32'h1 << PM_BIAS_EN);
      x = rnd();
      wr(A_DEPTH_ALPHA, x);
      s = 16'(rnd());
      pix(s, 16'h0, 24'h0);
      `CHK("bias", 16'(s + x[15:0]), px_depth_out)
      $display("pixel test done");
      wr(A_INTR_CTRL, 32'h1 << IC_USER_EN);
      wr(A_HOST_INTR, 32'h00000154);
      settle();
      `CHK("raise", 2'b10, {user_irq_pending, cmd_stall})
      rdchk(A_INTR_CTRL, 32'h00055820);
      wr(A_HOST_INTR, 32'h000002AF);
      repeat (4) settle();
      `CHK("stall", 2'b11, {user_irq_pending, cmd_stall})
      rdchk(A_INTR_CTRL, 32'h000AB820);
      wr(A_INTR_CTRL, 32'h00000020);
      settle();
      settle();
      `CHK("cleared", 2'b00, {user_irq_pending, cmd_stall})
      wr(A_HOST_INTR, 32'h00000003);
      settle();
      `CHK("no stall", 2'b00, {user_irq_pending, cmd_stall})
      wr(A_INTR_CTRL, 32'h0);
      wr(A_HOST_INTR, 32'h000003FC);
      settle();
      `CHK("dropped", 2'b00, {user_irq_pending, cmd_stall})
      rdchk(A_INTR_CTRL, 32'h0);
      rdchk(A_HOST_INTR, 32'h0);
      $display("interrupt test done");
      tally_and_finish();
   end
endmodule : testbench
`undef CHK
`default_nettype wire
